// [host_arb_pkg.sv]
// Package for the host bus arbitration and interrupt pin block.
// Assumes a single system bus clock domain and synchronous active-low reset.
package host_arb_pkg;

   // Arbitration states, Gray coded along idle, request, own, release.
   typedef enum logic [1:0] {
      ARB_IDLE = 2'b00,
      ARB_REQ = 2'b01,
      ARB_OWN = 2'b11,
      ARB_DROP = 2'b10
   } arb_state_t;

   // Default host data width in hold-style mode when no 8-bit choice is made.
   localparam logic RST_WIDE8 = 1'b0;
   localparam int SYNC_STAGES = 2;
   // Synchroniser restart value, bits {ack_n, release_n, busy_n, grant_n, hold_ack}.
   // The bus is taken as busy and ungranted until real pin levels have passed both stages.
   localparam logic [4:0] SYNC_RST = 5'h1a;

   // Pins sampled from the system bus, raw.
   typedef struct packed {
      logic style_hold;
      logic hold_ack_in;
      logic bus_grant_n;
      logic bus_busy_n;
      logic bus_release_n;
      logic host_irq_ack_n;
   } bus_in_t;

   // Complete state of the block.
   typedef struct packed {
      logic [4:0] sync1;
      logic [4:0] sync2;
      arb_state_t state;
      logic req;
      logic own;
      logic irq;
      logic ack_seen;
      logic [15:0] drive_data;
      logic drive_en;
      logic par_hi;
      logic par_lo;
   } arb_reg_t;

endpackage

// [host_arbiter_model.sv]
// Behavioural host arbiter that answers the block's bus request pins.
// Assumes the request pins change just after a rising clk edge.
`timescale 1ns/1ns
module host_arbiter_model (
   input wire logic clk,
   input wire logic style_hold,
   input wire logic hold_request_out,
   input wire logic bus_request_n,
   input wire logic slow,
   output logic hold_ack_in,
   output logic bus_grant_n
);
   int wait_n = 0;
   logic want;
   // The slow setting makes the block wait, as a busy host would.
   assign want = style_hold ? hold_request_out : !bus_request_n;
   always @(posedge clk) begin
      if (!want) wait_n <= slow ? 6 : 1;
      else if (wait_n > 0) wait_n <= wait_n - 1;
   end
   assign hold_ack_in = style_hold & want & (wait_n == 0);
   assign bus_grant_n = !(!style_hold & want & (wait_n == 0));
endmodule

// [host_bus_arb.sv]
// Host bus arbitration, ownership, interrupt and parity pin logic.
// Assumes all pins are synchronous to clk; the host arbiter keeps its own signalling.
// Overview of operation
// - Grant-style bus grant is active low and is synchronised here.
// - Hold-style request output is high while asking for the bus.
// - Grant-style request output is low while asking for the bus.
// - Low interrupt acknowledge with an interrupt pending makes the device drive its vector on the data bus.
// - Style select high selects hold-style mode, 8 or 16 bit wide.
// - Style select low selects grant-style mode, always 16 bits wide.
// - Hold-style interrupt request output is high when an interrupt is pending.
// - Grant-style interrupt request output is low when an interrupt is pending.
// - Bus-owned output is low while the device owns the system bus.
// - Bus-owned output enables the address and control transceivers.
// - Upper byte parity is odd parity of the upper byte lines.
// - Lower byte parity is odd parity of the lower byte lines.
// - Bus may be taken only when bus busy samples high with grant.
// - Bus release low ends ownership after the cycle, then rearbitrates.
`timescale 1ns/1ns
module host_bus_arb #(
   parameter logic [7:0] IRQ_VECTOR = 8'h40
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire host_arb_pkg::bus_in_t pins,
   input wire logic wide8_sel,
   input wire logic dma_pending,
   input wire logic dma_cycle_end,
   input wire logic irq_pending,
   input wire logic [7:0] upper_addr_data_byte,
   input wire logic [7:0] lower_addr_data_byte,
   input wire logic data_drive,
   input wire logic parity_upper_byte_in,
   input wire logic parity_lower_byte_in,
   output logic hold_request_out,
   output logic bus_request_n,
   output logic host_irq_high,
   output logic host_irq_n,
   output logic bus_owned_n,
   output logic dma_granted,
   output logic bus_8bit,
   output logic [15:0] vector_data_out,
   output logic vector_data_oe,
   output logic parity_upper_byte_out,
   output logic parity_lower_byte_out,
   output logic parity_oe,
   output logic parity_error
);

   host_arb_pkg::arb_reg_t st_r;
   host_arb_pkg::arb_reg_t st_nxt;
   logic grant_s;
   logic busy_free_s;
   logic release_s;
   logic ack_s;
   logic hold_mode;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised views of the arbiter pins; only the second stage is read.
   assign hold_mode = pins.style_hold;
   assign grant_s = hold_mode ? st_r.sync2[0] : ~st_r.sync2[1];
   assign busy_free_s = st_r.sync2[2];
   assign release_s = ~st_r.sync2[3];
   assign ack_s = ~st_r.sync2[4];

   // Next-state logic for the whole block.
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync1 = {pins.host_irq_ack_n, pins.bus_release_n, pins.bus_busy_n,
                      pins.bus_grant_n, pins.hold_ack_in};
      st_nxt.sync2 = st_r.sync1;
      st_nxt.irq = irq_pending;
      st_nxt.ack_seen = ack_s;
      case (st_r.state)
         host_arb_pkg::ARB_IDLE: begin
            if (dma_pending) begin
               st_nxt.state = host_arb_pkg::ARB_REQ;
               st_nxt.req = 1'b1;
            end
         end
         host_arb_pkg::ARB_REQ: begin
            // Ownership needs the grant and a free bus in the same sample.
            if (st_r.req && grant_s && busy_free_s) begin
               st_nxt.state = host_arb_pkg::ARB_OWN;
               st_nxt.own = 1'b1;
            end
         end
         host_arb_pkg::ARB_OWN: begin
            // Release is honoured only at a cycle boundary, never mid-cycle.
            if (dma_cycle_end && (release_s || !dma_pending || !grant_s)) begin
               st_nxt.state = host_arb_pkg::ARB_DROP;
               st_nxt.own = 1'b0;
               st_nxt.req = 1'b0;
            end
         end
         host_arb_pkg::ARB_DROP: begin
            // One idle cycle lets the arbiter see the request fall before a retry.
            st_nxt.state = host_arb_pkg::ARB_IDLE;
         end
         default: begin
            st_nxt.state = host_arb_pkg::ARB_IDLE;
            st_nxt.req = 1'b0;
            st_nxt.own = 1'b0;
         end
      endcase
      // Vector goes out while the acknowledge is held low and an interrupt is pending.
      st_nxt.drive_data = {8'h00, IRQ_VECTOR};
      st_nxt.drive_en = ack_s && st_r.irq;
      // Odd parity: the extra bit makes the count of ones odd.
      st_nxt.par_hi = ~(^upper_addr_data_byte);
      st_nxt.par_lo = ~(^lower_addr_data_byte);
   end

   // The single state register.
   // Stale synchroniser contents after reset must never read as a grant on a free bus.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.sync1 <= host_arb_pkg::SYNC_RST;
         st_r.sync2 <= host_arb_pkg::SYNC_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin polarity follows the selected style.
   assign hold_request_out = hold_mode & st_r.req;
   assign bus_request_n = hold_mode | ~st_r.req;
   assign host_irq_high = hold_mode & st_r.irq;
   assign host_irq_n = hold_mode | ~st_r.irq;
   assign bus_owned_n = ~st_r.own;
   assign dma_granted = st_r.own;
   assign bus_8bit = hold_mode & wide8_sel;
   assign vector_data_out = st_r.drive_data;
   assign vector_data_oe = st_r.drive_en;
   assign parity_upper_byte_out = st_r.par_hi;
   assign parity_lower_byte_out = st_r.par_lo;
   assign parity_oe = data_drive;
   // Incoming bytes are checked against the parity the source drove.
   assign parity_error = !data_drive &&
      ((parity_upper_byte_in == (^upper_addr_data_byte)) ||
       (parity_lower_byte_in == (^lower_addr_data_byte)));

   ////////////////////////////////////////////////////////////////////////////
   // Checks, each next to the rule that it guards.
   // Ownership is only ever taken from a synchronised grant and a free bus.
   a_own_needs_grant: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(st_r.own) |-> $past(grant_s) && $past(busy_free_s) && $past(st_r.req))
      else $error("Ownership taken without grant and free bus.");
   // The owned pin mirrors the owning state exactly.
   a_owned_pin_low: assert property (@(posedge clk) disable iff (!rst_b)
      bus_owned_n == !(st_r.state == host_arb_pkg::ARB_OWN))
      else $error("Owned pin disagrees with state.");
   // A release seen at a cycle end gives the bus up at the next edge.
   a_release_drops: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.own && dma_cycle_end && release_s |=> bus_owned_n)
      else $error("Bus not released after cycle.");
   // The request falls together with ownership.
   a_req_after_own: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(st_r.own) |-> !st_r.req)
      else $error("Request held after ownership.");
   // Hold style uses the high-active request and parks the other pin high.
   a_hold_req_pol: assert property (@(posedge clk) disable iff (!rst_b)
      hold_mode |-> (hold_request_out == st_r.req) && bus_request_n)
      else $error("Hold-style request polarity wrong.");
   // Grant style uses the low-active request and parks the other pin low.
   a_grant_req_pol: assert property (@(posedge clk) disable iff (!rst_b)
      !hold_mode |-> (bus_request_n == !st_r.req) && !hold_request_out)
      else $error("Grant-style request polarity wrong.");
   // A pending interrupt in hold style shows as a high level.
   a_irq_hold_pol: assert property (@(posedge clk) disable iff (!rst_b)
      hold_mode && irq_pending |=> host_irq_high && host_irq_n)
      else $error("Hold-style interrupt polarity wrong.");
   // A pending interrupt in grant style shows as a low level.
   a_irq_grant_pol: assert property (@(posedge clk) disable iff (!rst_b)
      !hold_mode && irq_pending |=> !host_irq_n && !host_irq_high)
      else $error("Grant-style interrupt polarity wrong.");
   // The vector only goes out after a synchronised acknowledge.
   a_vector_on_ack: assert property (@(posedge clk) disable iff (!rst_b)
      vector_data_oe |-> $past(ack_s) && vector_data_out[7:0] == IRQ_VECTOR)
      else $error("Vector driven without acknowledge.");
   // Upper parity makes the previous byte odd; the edge leaving reset is skipped.
   a_parity_odd: assert property (@(posedge clk) disable iff (!rst_b)
      $past(rst_b) |->
      ^{$past(upper_addr_data_byte), parity_upper_byte_out} == 1'b1)
      else $error("Upper parity not odd.");
   // Lower parity makes the previous byte odd; the edge leaving reset is skipped.
   a_parity_lo_odd: assert property (@(posedge clk) disable iff (!rst_b)
      $past(rst_b) |->
      ^{$past(lower_addr_data_byte), parity_lower_byte_out} == 1'b1)
      else $error("Lower parity not odd.");
   // A grant taken into ownership stood on the pin two synchroniser stages earlier.
   a_grant_sync: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(st_r.own) && !hold_mode |-> !$past(pins.bus_grant_n, 3))
      else $error("Grant used before synchronisation.");
   // Grant style never reports the narrow data path.
   a_width_sel: assert property (@(posedge clk) disable iff (!rst_b)
      !hold_mode |-> !bus_8bit)
      else $error("8-bit width in grant-style mode.");
   // Hold style follows the width select directly.
   a_width_hold: assert property (@(posedge clk) disable iff (!rst_b)
      hold_mode |-> bus_8bit == wide8_sel)
      else $error("Hold-style width does not follow select.");
   // A pending transfer in idle raises the request at the next edge.
   a_req_from_idle: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.state == host_arb_pkg::ARB_IDLE && dma_pending |=> st_r.req)
      else $error("Request not raised for pending transfer.");
   // With nothing to move the request stays low.
   a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.state == host_arb_pkg::ARB_IDLE && !dma_pending |=> !st_r.req)
      else $error("Request raised with nothing pending.");
   // Idle never shows ownership on either output.
   a_idle_not_owned: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.state == host_arb_pkg::ARB_IDLE |-> bus_owned_n && !dma_granted)
      else $error("Ownership shown while idle.");
   // The drop state lasts exactly one cycle.
   a_drop_to_idle: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.state == host_arb_pkg::ARB_DROP |=> st_r.state == host_arb_pkg::ARB_IDLE)
      else $error("Drop state did not return to idle.");
   // During the drop cycle the arbiter sees neither request nor ownership.
   a_drop_no_req: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.state == host_arb_pkg::ARB_DROP |-> !st_r.req && bus_owned_n)
      else $error("Request or ownership seen while dropping.");
   // An unfinished transfer asks for the bus again after the drop cycle.
   a_rearbitrate: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.state == host_arb_pkg::ARB_DROP ##1 dma_pending |=> st_r.req)
      else $error("No new request after release.");
   // Ownership is never given up in the middle of a cycle.
   a_own_holds: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.own && !dma_cycle_end |=> st_r.own)
      else $error("Bus dropped in mid-cycle.");
   // A finished transfer gives up the bus and the request at its last cycle.
   a_done_drops: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.own && dma_cycle_end && !dma_pending |=> bus_owned_n && !st_r.req)
      else $error("Bus kept after the transfer finished.");
   // Ownership is only held while the request stands.
   a_own_while_req: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.own |-> st_r.req)
      else $error("Ownership without a request.");
   // A busy bus keeps the block waiting.
   a_busy_blocks: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.state == host_arb_pkg::ARB_REQ && !busy_free_s |=> !st_r.own)
      else $error("Bus taken while busy.");
   // Without a grant the block keeps waiting.
   a_nogrant_blocks: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.state == host_arb_pkg::ARB_REQ && !grant_s |=> !st_r.own)
      else $error("Bus taken without a grant.");
   // A grant on a free bus is taken at the next edge.
   a_grant_taken: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.state == host_arb_pkg::ARB_REQ && grant_s && busy_free_s |=> !bus_owned_n)
      else $error("Grant on a free bus not taken.");
   // The busy level that allowed ownership stood on the pin two stages earlier.
   a_busy_synced: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(st_r.own) |-> $past(pins.bus_busy_n, 3))
      else $error("Busy level used before synchronisation.");
   // In hold style the acknowledge that allowed ownership passed both stages.
   a_hold_ack_synced: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(st_r.own) && hold_mode |-> $past(pins.hold_ack_in, 3))
      else $error("Hold acknowledge used before synchronisation.");
   // The internal grant flag and the transceiver enable always agree.
   a_granted_mirror: assert property (@(posedge clk) disable iff (!rst_b)
      dma_granted == !bus_owned_n)
      else $error("Grant flag and transceiver enable disagree.");
   // Hold style without a pending interrupt keeps the request pin low.
   a_hold_irq_idle: assert property (@(posedge clk) disable iff (!rst_b)
      hold_mode && !irq_pending |=> !host_irq_high)
      else $error("Hold-style interrupt shown with none pending.");
   // Grant style without a pending interrupt keeps the request pin high.
   a_grant_irq_idle: assert property (@(posedge clk) disable iff (!rst_b)
      !hold_mode && !irq_pending |=> host_irq_n)
      else $error("Grant-style interrupt shown with none pending.");
   // Only one interrupt pin is ever active, so no host sees a double request.
   a_irq_pins_apart: assert property (@(posedge clk) disable iff (!rst_b)
      !(host_irq_high && !host_irq_n))
      else $error("Both interrupt pins active.");
   // The vector needs both a pending interrupt and a seen acknowledge.
   a_vector_needs_irq: assert property (@(posedge clk) disable iff (!rst_b)
      vector_data_oe |-> $past(st_r.irq) && st_r.ack_seen)
      else $error("Vector driven with no interrupt pending.");
   // An acknowledged interrupt puts the vector out at the next edge.
   a_vector_on_time: assert property (@(posedge clk) disable iff (!rst_b)
      ack_s && st_r.irq |=> vector_data_oe)
      else $error("Vector not driven on acknowledge.");
   // Without an acknowledge the data bus is left to the host.
   a_no_ack_quiet: assert property (@(posedge clk) disable iff (!rst_b)
      !ack_s |=> !vector_data_oe)
      else $error("Vector driven after acknowledge ended.");
   // An even received upper byte is flagged.
   a_par_hi_err: assert property (@(posedge clk) disable iff (!rst_b)
      !data_drive && !(^{upper_addr_data_byte, parity_upper_byte_in}) |-> parity_error)
      else $error("Upper parity error missed.");
   // An even received lower byte is flagged.
   a_par_lo_err: assert property (@(posedge clk) disable iff (!rst_b)
      !data_drive && !(^{lower_addr_data_byte, parity_lower_byte_in}) |-> parity_error)
      else $error("Lower parity error missed.");
   // Two odd received bytes raise no error.
   a_par_clean: assert property (@(posedge clk) disable iff (!rst_b)
      !data_drive && (^{upper_addr_data_byte, parity_upper_byte_in}) &&
      (^{lower_addr_data_byte, parity_lower_byte_in}) |-> !parity_error)
      else $error("Parity error on odd bytes.");
   // While the block sources the bytes it drives parity and checks nothing.
   a_par_quiet_out: assert property (@(posedge clk) disable iff (!rst_b)
      data_drive |-> !parity_error && parity_oe)
      else $error("Parity checked while driving.");
   // The second synchroniser stage only ever copies the first.
   a_sync_chain: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.sync2 == $past(st_r.sync1))
      else $error("Synchroniser stages out of step.");

endmodule

// [testbench.sv]
// Self-checking bench for the host bus arbitration and interrupt pins.
// Assumes the arbiter model file is compiled before this one.
`timescale 1ns/1ns
module testbench;
   logic clk = 0, rst_b = 0, style = 1, busy_n = 1, rls_n = 1, iack_n = 1, wide8 = 0;
   logic dma = 0, cend = 0, irq = 0, drv = 0, pu = 0, pl = 0, slow = 0;
   logic [7:0] ub = 0, lb = 0;
   logic ack, gnt_n, hrq, brq_n, ih, in_n, own_n, gr, b8, voe, puo, plo, poe, perr;
   logic [15:0] vout;
   logic [1:0] q[$];
   host_arb_pkg::bus_in_t pins;
   int mismatches = 0, compares = 0;
   assign pins = {style, ack, gnt_n, busy_n, rls_n, iack_n};
   always #25 clk = ~clk;
   host_arbiter_model u_host_arbiter_model (.clk(clk), .style_hold(style),
      .hold_request_out(hrq), .bus_request_n(brq_n), .slow(slow), .hold_ack_in(ack),
      .bus_grant_n(gnt_n));
   host_bus_arb u_host_bus_arb (.clk(clk), .rst_b(rst_b), .pins(pins), .wide8_sel(wide8),
      .dma_pending(dma), .dma_cycle_end(cend), .irq_pending(irq), .upper_addr_data_byte(ub),
      .lower_addr_data_byte(lb), .data_drive(drv), .parity_upper_byte_in(pu),
      .parity_lower_byte_in(pl), .hold_request_out(hrq), .bus_request_n(brq_n),
      .host_irq_high(ih), .host_irq_n(in_n), .bus_owned_n(own_n), .dma_granted(gr),
      .bus_8bit(b8), .vector_data_out(vout), .vector_data_oe(voe),
      .parity_upper_byte_out(puo), .parity_lower_byte_out(plo), .parity_oe(poe),
      .parity_error(perr));
   ////////////////////////////////////////////////////////////////////////////////
   // A pin result is compared with the value reckoned from the pin levels.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Waits a bounded time, since a slow grant must still arrive.
   task automatic wait_own(input logic want_own);
      int n = 0;
      while (own_n !== !want_own && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk("bus_owned_n", !want_own, own_n);
      chk("dma_granted", want_own, gr);
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // The watchdog stops a hung handshake long after the roughly 110 cycles needed.
   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end
   // Both interface styles, then a busy bus, then random parity traffic.
   initial begin
      void'($urandom(32'h5a3068b9));
      repeat (10) @(negedge clk);
      chk("reset_outputs", 16'h1, {voe, gr, own_n});
      rst_b = 1;
      for (int s = 1; s >= 0; s--) begin
         style = s[0];
         slow = s[0];
         wide8 = 1;
         irq = 1;
         dma = 1;
         repeat (2) @(negedge clk);
         chk("bus_8bit", s[0], b8);
         chk("request", s[0] ? 2'b11 : 2'b00, {hrq, brq_n});
         chk("irq", s[0] ? 2'b11 : 2'b00, {ih, in_n});
         wide8 = 0;
         @(negedge clk);
         chk("bus_8bit_narrow", 0, b8);
         wait_own(1);
         iack_n = 0;
         repeat (4) @(negedge clk);
         chk("vector_oe", 1, voe);
         chk("vector", 16'h0040, vout);
         iack_n = 1;
         rls_n = 0;
         repeat (3) @(negedge clk);
         cend = 1;
         @(negedge clk);
         cend = 0;
         wait_own(0);
         rls_n = 1;
         wait_own(1);
         dma = 0;
         irq = 0;
         // Ownership only ends at a cycle boundary, so the last cycle is marked.
         cend = 1;
         @(negedge clk);
         cend = 0;
         wait_own(0);
         repeat (3) @(negedge clk);
         chk("request_idle", 2'b01, {hrq, brq_n});
         chk("irq_idle", 2'b01, {ih, in_n});
      end
      busy_n = 0;
      dma = 1;
      repeat (12) @(negedge clk);
      chk("busy_own", 1, own_n);
      busy_n = 1;
      wait_own(1);
      dma = 0;
      cend = 1;
      @(negedge clk);
      cend = 0;
      wait_own(0);
      // Parity outputs follow the byte seen one cycle earlier.
      repeat (24) begin
         @(negedge clk);
         if (q.size() > 0) chk("parity_out", q.pop_front(), {puo, plo});
         {ub, lb, pu, pl, drv} = 19'($urandom);
         q.push_back({~^ub, ~^lb});
         #1;
         chk("parity_oe", drv, poe);
         chk("parity_err", !drv && (!(^{ub, pu}) || !(^{lb, pl})), perr);
      end
      print_verdict();
   end
endmodule
